// [d2p_pkg.sv]
// Package: register map, field layout and types of the die-two control bank
package d2p_pkg;

  // ****************************************************************
  // Bus and register geometry
  // ****************************************************************
  localparam int unsigned D2P_DATA_W  = 32;
  localparam int unsigned D2P_ADDR_W  = 12;
  localparam int unsigned D2P_REG_W   = 16;
  localparam int unsigned D2P_ODD_CH  = 8;
  localparam int unsigned D2P_PH_CH   = 4;
  localparam int unsigned D2P_PH_W    = 4;
  localparam int unsigned D2P_DEG_W   = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0] D2P_IDX_EXT_ADDR     = 10'h001;
  localparam logic [9:0] D2P_IDX_APPLIED      = 10'h002;
  localparam logic [9:0] D2P_IDX_POWER_CTRL   = 10'h0D5;
  localparam logic [9:0] D2P_IDX_MIXER_PHASE  = 10'h0D7;

  localparam logic [D2P_ADDR_W-1:0] D2P_ADDR_EXT_ADDR =
    {D2P_IDX_EXT_ADDR, 2'h0};
  localparam logic [D2P_ADDR_W-1:0] D2P_ADDR_APPLIED =
    {D2P_IDX_APPLIED, 2'h0};
  localparam logic [D2P_ADDR_W-1:0] D2P_ADDR_POWER_CTRL =
    {D2P_IDX_POWER_CTRL, 2'h0};
  localparam logic [D2P_ADDR_W-1:0] D2P_ADDR_MIXER_PHASE =
    {D2P_IDX_MIXER_PHASE, 2'h0};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned D2P_BIT_GLOBAL_PD  = 15;
  localparam int unsigned D2P_BIT_QUICK_PD   = 14;
  localparam int unsigned D2P_BIT_AMP_PD     = 13;
  localparam int unsigned D2P_BIT_ATTEN_PD   = 12;
  localparam int unsigned D2P_BIT_MODE_HI    = 11;
  localparam int unsigned D2P_BIT_MODE_LO    = 10;
  localparam int unsigned D2P_BIT_LOW_NF     = 9;
  localparam int unsigned D2P_BIT_CHAN_PD_HI = 7;
  localparam int unsigned D2P_BIT_EXT_ADDR   = 0;

  // ****************************************************************
  // Reset values and conversion constants
  // ****************************************************************
  localparam logic [D2P_REG_W-1:0] D2P_RST_POWER_CTRL  = 16'h0000;
  localparam logic [D2P_REG_W-1:0] D2P_RST_MIXER_PHASE = 16'h0000;
  localparam logic                 D2P_RST_EXT_ADDR    = 1'h0;
  // Phase step of 22.5 degrees, held in tenths of a degree
  localparam logic [D2P_DEG_W-1:0] D2P_PHASE_STEP_DECIDEG = 12'h0E1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    D2P_MODE_LOW_NOISE    = 2'h0,
    D2P_MODE_LOW_POWER    = 2'h1,
    D2P_MODE_MEDIUM_POWER = 2'h2,
    D2P_MODE_RESERVED     = 2'h3
  } d2p_power_mode_type;

  typedef struct packed {
    logic                    global_pd;
    logic                    quick_pd;
    logic                    amp_pd;
    logic                    atten_gain_pd;
    d2p_power_mode_type      mode;
    logic                    low_nf;
    logic [D2P_ODD_CH-1:0]   chan_pd;
  } d2p_die_ctrl_type;

  typedef struct packed {
    logic amp_pd;
    logic atten_gain_pd;
    logic slow_wake;
    logic fast_wake;
  } d2p_chan_pwr_type;

endpackage

// [d2p_chan_decode.sv]
// Per-channel power decode for one odd channel of die two
`timescale 1ns/1ps
`default_nettype none
module d2p_chan_decode
  import d2p_pkg::*;
#(
  parameter int unsigned IDX = 0
) (
  input  wire d2p_die_ctrl_type ctrl,
  output var  d2p_chan_pwr_type pwr
);

  logic die_off;

  // Converter channel has no control here, so it never powers down
  always_comb begin
    die_off           = ctrl.global_pd | ctrl.quick_pd;       // [R1] [R2] [R3]
    pwr.amp_pd        = die_off | ctrl.amp_pd
                      | ctrl.chan_pd[IDX];                    // [R4] [R11] [R12]
    pwr.atten_gain_pd = die_off | ctrl.atten_gain_pd
                      | ctrl.chan_pd[IDX];                    // [R5] [R11] [R12]
    pwr.slow_wake     = ctrl.global_pd;                       // [R1]
    pwr.fast_wake     = ctrl.quick_pd & ~ctrl.global_pd;      // [R2]
  end

endmodule
`default_nettype wire

// [d2p_regs.sv]
// APB register bank steering power and mixer phase of die two
//
// Summary of operation
// (R1) With extended addressing on, the global bit fully powers down die two's amplifier, attenuator and gain stage for slow wake.
// (R2) With extended addressing on, the quick bit partially powers down those stages of die two for fast wake.
// (R3) The global and quick bits act on the front-end die only and never on the converters.
// (R4) With extended addressing on, the amplifier bit powers down only die two's input amplifier.
// (R5) With extended addressing on, the attenuator bit powers down only die two's attenuator and gain amplifier.
// (R6) The two-bit mode field picks low noise, low power or medium power.
// (R7) Software must not write the reserved mode code.
// (R8) The chosen mode reaches die two only while extended addressing is on.
// (R9) Software must set the mode field to low noise before writing the low-noise-figure bit.
// (R10) With extended addressing on, the low-noise-figure bit turns the improved noise mode on or off on die two.
// (R11) Bits 7 to 0 power down channels 15 down to 1 while extended addressing is on.
// (R12) A channel power-down stops only that channel's front-end stages, not its converter.
// (R13) Each four-bit phase code sets the mixer phase to the code times 22.5 degrees.
// (R14) Phase nibbles from high to low program channels 7, 5, 3 and 1 while extended addressing is on.
// (R15) A cleared power-down bit leaves its circuits in normal operation.
// (R16) While extended addressing is off, the die-two fields have no effect.
`timescale 1ns/1ps
`default_nettype none
module d2p_regs
  import d2p_pkg::*;
#(
  parameter int unsigned ODD_CH = D2P_ODD_CH,
  parameter int unsigned PH_CH  = D2P_PH_CH
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [D2P_ADDR_W-1:0] paddr,
  input  wire logic [D2P_DATA_W-1:0] pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic                       pslverr,
  output logic [D2P_DATA_W-1:0]      prdata,
  output logic                       ext_addr_active,
  output d2p_die_ctrl_type           die_ctrl,
  output d2p_chan_pwr_type           chan_pwr [ODD_CH],
  output logic [D2P_DEG_W-1:0]       mixer_phase_decideg [PH_CH]
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [D2P_REG_W-1:0]  power_ctrl;
  logic [D2P_REG_W-1:0]  mixer_phase;
  logic                  ext_addr;
  logic [D2P_REG_W-1:0]  next_power_ctrl;
  logic [D2P_REG_W-1:0]  next_mixer_phase;
  logic                  next_ext_addr;
  logic                  next_pready;
  logic                  next_pslverr;
  logic [D2P_DATA_W-1:0] next_prdata;
  logic                  setup;
  logic                  wr_go;
  logic [D2P_REG_W-1:0]  wr_power;
  logic [D2P_REG_W-1:0]  wr_phase;

  // Only the low two lanes exist; upper lanes are dropped
  function automatic logic [D2P_REG_W-1:0] merge_lanes(
    input logic [D2P_REG_W-1:0]  old_val,
    input logic [D2P_DATA_W-1:0] data,
    input logic [3:0]            strb
  );
    logic [D2P_REG_W-1:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // ****************************************************************
  // APB slave: no wait state, answer registered in setup cycle
  // ****************************************************************
  always_comb begin
    setup            = psel & ~penable;
    wr_go            = psel & penable & pready & pwrite;
    next_pready      = setup;
    next_pslverr     = 1'b0;
    next_prdata      = prdata;
    next_power_ctrl  = power_ctrl;
    next_mixer_phase = mixer_phase;
    next_ext_addr    = ext_addr;
    wr_power         = merge_lanes(power_ctrl, pwdata, pstrb);
    wr_phase         = merge_lanes(mixer_phase, pwdata, pstrb);
    // Low-noise-figure bit only takes a write while mode is low noise
    if (power_ctrl[D2P_BIT_MODE_HI:D2P_BIT_MODE_LO] != D2P_MODE_LOW_NOISE)
    begin
      wr_power[D2P_BIT_LOW_NF] = power_ctrl[D2P_BIT_LOW_NF];   // [R9]
    end
    if (setup) begin
      next_prdata = '0;
      case (paddr)
        D2P_ADDR_EXT_ADDR: begin
          next_prdata[D2P_BIT_EXT_ADDR] = ext_addr;
        end
        D2P_ADDR_APPLIED: begin
          next_prdata[$bits(d2p_die_ctrl_type)-1:0] = die_ctrl;
        end
        D2P_ADDR_POWER_CTRL: begin
          next_prdata[D2P_REG_W-1:0] = power_ctrl;
        end
        D2P_ADDR_MIXER_PHASE: begin
          next_prdata[D2P_REG_W-1:0] = mixer_phase;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
      // Status word is read-only; writing it is an error
      if (pwrite && paddr == D2P_ADDR_APPLIED) begin
        next_pslverr = 1'b1;
      end
    end
    if (wr_go) begin
      case (paddr)
        D2P_ADDR_EXT_ADDR: begin
          if (pstrb[0]) begin
            next_ext_addr = pwdata[D2P_BIT_EXT_ADDR];
          end
        end
        D2P_ADDR_POWER_CTRL: begin
          next_power_ctrl = wr_power;
        end
        D2P_ADDR_MIXER_PHASE: begin
          next_mixer_phase = wr_phase;
        end
        default: begin
          next_ext_addr = ext_addr;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= '0;
      power_ctrl  <= D2P_RST_POWER_CTRL;
      mixer_phase <= D2P_RST_MIXER_PHASE;
      ext_addr    <= D2P_RST_EXT_ADDR;
    end else begin
      pready      <= next_pready;
      pslverr     <= next_pslverr;
      prdata      <= next_prdata;
      power_ctrl  <= next_power_ctrl;
      mixer_phase <= next_mixer_phase;
      ext_addr    <= next_ext_addr;
    end
  end

  // ****************************************************************
  // Applied die-two control
  // ****************************************************************
  d2p_die_ctrl_type next_die_ctrl;
  logic             next_ext_active;
  d2p_power_mode_type req_mode;

  always_comb begin
    next_ext_active = next_ext_addr;
    next_die_ctrl   = die_ctrl;
    req_mode = d2p_power_mode_type'(
      next_power_ctrl[D2P_BIT_MODE_HI:D2P_BIT_MODE_LO]);
    // Fields only reach die two under extended addressing
    if (next_ext_addr) begin                                  // [R16]
      next_die_ctrl.global_pd     =
        next_power_ctrl[D2P_BIT_GLOBAL_PD];                   // [R1] [R15]
      next_die_ctrl.quick_pd      =
        next_power_ctrl[D2P_BIT_QUICK_PD];                    // [R2] [R15]
      next_die_ctrl.amp_pd        =
        next_power_ctrl[D2P_BIT_AMP_PD];                      // [R4] [R15]
      next_die_ctrl.atten_gain_pd =
        next_power_ctrl[D2P_BIT_ATTEN_PD];                    // [R5] [R15]
      next_die_ctrl.low_nf        =
        next_power_ctrl[D2P_BIT_LOW_NF];                      // [R10]
      next_die_ctrl.chan_pd       =
        next_power_ctrl[D2P_BIT_CHAN_PD_HI:0];                // [R11]
      // Reserved mode code keeps the last legal mode in force
      case (req_mode)
        D2P_MODE_LOW_NOISE,
        D2P_MODE_LOW_POWER,
        D2P_MODE_MEDIUM_POWER: begin
          next_die_ctrl.mode = req_mode;                      // [R6] [R8]
        end
        default: begin
          next_die_ctrl.mode = die_ctrl.mode;                 // [R7]
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      die_ctrl        <= '0;
      ext_addr_active <= 1'b0;
    end else begin
      die_ctrl        <= next_die_ctrl;
      ext_addr_active <= next_ext_active;
    end
  end

  // ****************************************************************
  // Per-channel power outputs
  // ****************************************************************
  d2p_chan_pwr_type chan_dec [ODD_CH];

  genvar gi;
  generate
    for (gi = 0; gi < ODD_CH; gi++) begin : g_chan
      d2p_chan_decode #(
        .IDX (gi)
      ) u_dec (
        .ctrl (next_die_ctrl),
        .pwr  (chan_dec[gi])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_pwr[gi] <= '0;
        end else begin
          chan_pwr[gi] <= chan_dec[gi];                       // [R12]
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Mixer phase outputs, nibble k drives channel 2k+1
  // ****************************************************************
  logic [D2P_DEG_W-1:0] next_phase [PH_CH];

  generate
    for (gi = 0; gi < PH_CH; gi++) begin : g_phase
      always_comb begin
        next_phase[gi] = mixer_phase_decideg[gi];
        if (next_ext_addr) begin                              // [R14] [R16]
          next_phase[gi] = D2P_DEG_W'(
            next_mixer_phase[gi*D2P_PH_W +: D2P_PH_W]
            * D2P_PHASE_STEP_DECIDEG);                        // [R13]
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mixer_phase_decideg[gi] <= '0;
        end else begin
          mixer_phase_decideg[gi] <= next_phase[gi];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [d2p_regs_monitor.sv]
// Checker: port-level behaviour of the die-two control bank
`timescale 1ns/1ps
`default_nettype none
module d2p_regs_monitor
  import d2p_pkg::*;
#(
  parameter int unsigned ODD_CH = D2P_ODD_CH,
  parameter int unsigned PH_CH  = D2P_PH_CH
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 ext_addr_active,
  input wire d2p_die_ctrl_type     die_ctrl,
  input wire d2p_chan_pwr_type     chan_pwr [ODD_CH],
  input wire logic [D2P_DEG_W-1:0] mixer_phase_decideg [PH_CH]
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // Bus timing
  // ****************************************************************
  property p_rdy_lat; psel && !penable |=> pready; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready late");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready stuck");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");

  // ****************************************************************
  // Applied controls
  // ****************************************************************
  property p_glob; die_ctrl.global_pd |-> chan_pwr[7] == 4'hE; endproperty
  a_glob: assert property (p_glob) else $error("global pd");
  property p_quick;
    die_ctrl[14:13] == 2'h1 |-> chan_pwr[5].fast_wake && chan_pwr[5].amp_pd;
  endproperty
  a_quick: assert property (p_quick) else $error("quick pd");
  property p_amp;
    die_ctrl[14:11] == 4'h2 && !die_ctrl.chan_pd[3] |-> chan_pwr[3] == 4'h8;
  endproperty
  a_amp: assert property (p_amp) else $error("amp pd");
  property p_atten;
    die_ctrl[14:11] == 4'h1 && !die_ctrl.chan_pd[6] |-> chan_pwr[6] == 4'h4;
  endproperty
  a_atten: assert property (p_atten) else $error("atten pd");
  property p_mode; die_ctrl.mode != D2P_MODE_RESERVED; endproperty
  a_mode: assert property (p_mode) else $error("reserved mode");
  property p_chan;
    die_ctrl.chan_pd[4] |-> chan_pwr[4].amp_pd && chan_pwr[4].atten_gain_pd;
  endproperty
  a_chan: assert property (p_chan) else $error("chan pd");
  // Ext off on two edges in a row: die_ctrl and phase output 3 may not move
  property p_hold;
    !ext_addr_active ##1 !ext_addr_active
      |-> $stable(die_ctrl) && $stable(mixer_phase_decideg[3]);
  endproperty
  a_hold: assert property (p_hold) else $error("applied moved");
endmodule

bind d2p_regs d2p_regs_monitor #(.ODD_CH(ODD_CH), .PH_CH(PH_CH)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .ext_addr_active(ext_addr_active),
  .die_ctrl(die_ctrl), .chan_pwr(chan_pwr),
  .mixer_phase_decideg(mixer_phase_decideg)
);
`default_nettype wire

// [d2p_regs_test.sv]
// Testbench: APB scenarios for the die-two control bank
`timescale 1ns/1ps
`default_nettype none
module d2p_regs_test;
  import d2p_pkg::*;
  localparam logic [11:0] PC = D2P_ADDR_POWER_CTRL;
  localparam logic [11:0] PM = D2P_ADDR_MIXER_PHASE;
  localparam logic [11:0] AE = D2P_ADDR_EXT_ADDR;
  localparam logic [11:0] AS = D2P_ADDR_APPLIED;
  logic                  pclk, presetn, psel, penable, pwrite;
  logic [D2P_ADDR_W-1:0] paddr;
  logic [D2P_DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0]            pstrb, st;
  logic                  pready, pslverr, ext_addr_active, er;
  d2p_die_ctrl_type      die_ctrl;
  d2p_chan_pwr_type      chan_pwr [D2P_ODD_CH];
  logic [D2P_DEG_W-1:0]  mixer_phase_decideg [D2P_PH_CH];
  int                    error_cnt, tests_run;

  d2p_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .ext_addr_active(ext_addr_active), .die_ctrl(die_ctrl),
    .chan_pwr(chan_pwr), .mixer_phase_decideg(mixer_phase_decideg)
  );

  always #5 pclk = ~pclk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] dc(input logic [15:0] v);
    return {17'h0, v[15:9], v[7:0]};
  endfunction

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask

  // Answer taken at the edge that sees pready; checks run at the falling
  // edge so the outputs launched by the commit edge have settled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task pw(input logic [15:0] v, input int i, input logic [3:0] ex);
    apb(1'b1, PC, {16'h0, v});
    chk("chan_pwr", {28'h0, ex}, {28'h0, chan_pwr[i]});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    apb(1'b0, PC, 32'h0);
    chk("pc_rst", 32'h0, rd);
    apb(1'b0, PM, 32'h0);
    chk("ph_rst", 32'h0, rd);
    chk("ext_rst", 32'h0, {31'h0, ext_addr_active});
    $display("t_reset done");
  endtask

  task t_apply;
    apb(1'b1, PC, 32'hB2A5);
    apb(1'b1, PM, 32'hFE31);
    chk("hold_dc", 32'h0, {17'h0, die_ctrl});
    chk("hold_ph", 32'h0, {20'h0, mixer_phase_decideg[3]});
    apb(1'b1, AE, 32'h1);
    chk("dc_on", dc(16'hB2A5), {17'h0, die_ctrl});
    chk("glob", 32'hE, {28'h0, chan_pwr[1]});
    for (int k = 0; k < 4; k++) begin
      chk("phase", {20'h0, D2P_PHASE_STEP_DECIDEG} * ((32'hFE31 >> (4 * k))
        & 32'hF), {20'h0, mixer_phase_decideg[k]});
    end
    apb(1'b0, AS, 32'h0);
    chk("status", dc(16'hB2A5), rd);
    // Only lane 0 enabled: upper byte and upper lanes must be kept out
    st = 4'h1;
    apb(1'b1, PM, 32'hAB123434);
    st = 4'h3;
    apb(1'b0, PM, 32'h0);
    chk("strb", 32'hFE34, rd);
    $display("t_apply done");
  endtask

  task t_power;
    pw(16'h4000, 5, 4'hD);
    pw(16'h2000, 3, 4'h8);
    pw(16'h1000, 6, 4'h4);
    pw(16'h0010, 4, 4'hC);
    pw(16'h0010, 3, 4'h0);
    pw(16'h0000, 0, 4'h0);
    $display("t_power done");
  endtask

  task t_modes;
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, PC, (m % 3) << 10);
      chk("mode", m % 3, {30'h0, die_ctrl.mode});
    end
    apb(1'b1, PC, 32'h0800);
    apb(1'b1, PC, 32'h0C00);
    chk("rsv_mode", 32'h2, {30'h0, die_ctrl.mode});
    apb(1'b1, PC, 32'h0400);
    apb(1'b1, PC, 32'h0600);
    apb(1'b0, PC, 32'h0);
    chk("nf_gate", 32'h0400, rd);
    apb(1'b1, PC, 32'h0);
    apb(1'b1, PC, 32'h0200);
    chk("nf_on", 32'h1, {31'h0, die_ctrl.low_nf});
    apb(1'b1, PC, 32'h0);
    chk("nf_off", 32'h0, {31'h0, die_ctrl.low_nf});
    $display("t_modes done");
  endtask

  task t_bad;
    apb(1'b0, 12'h3FC, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, AS, 32'h7FFF);
    chk("ro_err", 32'h1, {31'h0, er});
    apb(1'b0, AS, 32'h0);
    chk("ro_keep", 32'h0, rd);
    $display("t_bad done");
  endtask

  task close_out;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'h3;
    st = 4'h3;
    error_cnt = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_apply;
    t_power;
    t_modes;
    t_bad;
    close_out;
  end

  // Whole run is under a hundred cycles; this is far beyond it
  initial begin
    #20000;
    error_cnt++;
    $display("BAD watchdog exp done got hang");
    close_out;
  end
endmodule
`default_nettype wire
